/* File: design/dcc_chan.sv */
// Channel engine: configuration, address stepping, counters and request pending state
module dcc_chan
	import dcc_pkg::*;
#(
	parameter int unsigned ADDR_W = DCC_ADDR_W
) (
	input  wire logic              mclk,
	input  wire logic              reset,
	input  wire logic              en,
	input  wire logic              wr_mem,
	input  wire logic              wr_io,
	input  wire logic              wr_cnt,
	input  wire logic              wr_mode,
	input  wire logic              wr_blk,
	input  wire logic [31:0]       wdata,
	input  wire logic              go,
	input  wire logic              req_evt,
	input  wire logic              unit_done,
	output logic      [ADDR_W-1:0] mem_addr,
	output logic      [ADDR_W-1:0] io_addr,
	output logic      [15:0]       cnt_now,
	output logic      [15:0]       blk_now,
	output logic      [15:0]       mode,
	output logic                   want,
	output logic                   end_evt
);

	logic       [ADDR_W-1:0] mem_init_q;
	logic       [ADDR_W-1:0] mem_q;
	logic       [ADDR_W-1:0] io_q;
	logic       [15:0]       cnt_init_q;
	logic       [15:0]       cnt_q;
	logic       [15:0]       blk_q;
	logic       [15:0]       mode_q;
	logic                    pend_q;
	dcc_xmode_t              xmode;

	// ----------------------------------------------------------------
	// Stepping and counting
	// ----------------------------------------------------------------
	assign xmode = dcc_xmode(mode_q);
	wire                is_rep    = (xmode == DCC_XM_REPEAT);
	wire                is_blk    = (xmode == DCC_XM_BLOCK);
	wire                short_cnt = is_rep | is_blk;
	wire                down      = mode_q[DCC_MD_DOWN_BIT];
	wire   [ADDR_W-1:0] step      = mode_q[DCC_MD_WORD_BIT] ? ADDR_W'(2) : ADDR_W'(1);
	wire   [ADDR_W-1:0] mem_step  = (xmode == DCC_XM_IDLE) ? mem_q :
		(down ? mem_q - step : mem_q + step);
	// Count 0 stands for 65536 (full) or 256 (short) units
	wire                last_unit = short_cnt ? (cnt_q[7:0] == 8'h01) : (cnt_q == 16'h0001);
	wire   [15:0]       cnt_dec   = short_cnt ? {cnt_q[15:8], cnt_q[7:0] - 8'h01} :
		cnt_q - 16'h0001;
	wire                blk_end   = is_blk & last_unit & (blk_q == 16'h0001);

	assign end_evt  = unit_done & last_unit & ~is_rep & (~is_blk | blk_end);
	assign want     = go & (dcc_burst(mode_q) | pend_q);
	assign mem_addr = mem_q;
	assign io_addr  = io_q;
	assign cnt_now  = cnt_q;
	assign blk_now  = blk_q;
	assign mode     = mode_q;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	// Only a unit already in flight moves on while go is low, so a suspended channel resumes in place
	always_ff @(posedge mclk) begin
		if (reset) begin
			mem_init_q <= '0;
			mem_q      <= '0;
			io_q       <= '0;
			cnt_init_q <= 16'h0000;
			cnt_q      <= 16'h0000;
			blk_q      <= 16'h0000;
			mode_q     <= DCC_MODE_RST;
			pend_q     <= 1'b0;
		end else if (en) begin
			if (wr_mem) begin
				mem_init_q <= wdata[ADDR_W-1:0];
				mem_q      <= wdata[ADDR_W-1:0];
			end else if (unit_done) begin
				mem_q <= (is_rep && last_unit) ? mem_init_q : mem_step;
			end
			if (wr_io) begin
				io_q <= wdata[ADDR_W-1:0];
			end
			if (wr_cnt) begin
				cnt_init_q <= wdata[15:0];
				cnt_q      <= wdata[15:0];
			end else if (unit_done) begin
				cnt_q <= (short_cnt && last_unit) ? cnt_init_q : cnt_dec;
			end
			if (wr_mode) begin
				mode_q <= wdata[15:0];
			end
			if (wr_blk) begin
				blk_q <= wdata[15:0];
			end else if (unit_done && is_blk && last_unit) begin
				blk_q <= blk_q - 16'h0001;
			end
			// A new request wins over the clear of the one just served
			pend_q <= (pend_q & ~(unit_done & (~is_blk | last_unit))) | (req_evt & go);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking dcc_cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	idle_addr_a: assert property (en && unit_done && !wr_mem && xmode == DCC_XM_IDLE
		|=> mem_q == $past(mem_q)) else $error("idle mode moved the address");
	seq_step_a: assert property (en && unit_done && !wr_mem && xmode == DCC_XM_SEQ && !down
		|=> mem_q == $past(mem_q) + $past(step)) else $error("sequential step wrong");
	repeat_reload_a: assert property (en && unit_done && !wr_mem && !wr_cnt && is_rep
		&& last_unit |=> mem_q == mem_init_q && cnt_q == cnt_init_q)
		else $error("repeat reload missing");
	hold_state_a: assert property (!go && !wr_mem && !wr_cnt && !unit_done
		|=> $stable(mem_q) && $stable(cnt_q)) else $error("suspended channel moved");
	req_pend_a: assert property (en && req_evt && go |=> pend_q)
		else $error("request lost");
	repeat_cov: cover property (en && unit_done && is_rep && last_unit);

endmodule : dcc_chan

/* File: design/dcc_ctrl.sv */
// Top level: register slave, master enables, request routing and bus sequencer of DMA channels
// Operation
// - Channel pair 1 transfers only while its master and transfer enables are both one.
// - NMI during a burst clears master enable, halts transfer, releases the bus.
// - Writing master enable to one again resumes the halted burst transfer.
// - In block mode NMI leaves master enable alone and transfer continues.
// - Master enable resets to zero, clears on zero write, sets after read-zero-then-write-one.
// - Dual address: each request moves one unit (one block in block mode), read at source, write at destination.
// - Sequential steps the address by one or two; idle keeps it; counts to 65536.
// - Repeat mode reloads start address and count after 1 to 256 transfers.
// - Single address moves a unit in one cycle, device picked by acknowledge strobe.
// - Four independent channels; external request and single address on B channels only.
// - Requests come from six timers, serial send/receive done, A/D end or pin.
// - Block counter drops per block; at zero transfer enable clears and transfer stops.
// - Block end with end interrupt enable set raises an interrupt request.
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
module dcc_ctrl
	import dcc_pkg::*;
#(
	parameter int unsigned ADDR_W = DCC_ADDR_W
) (
	input  wire logic              mclk,
	input  wire logic              reset,
	input  wire logic              en,
	input  wire logic [7:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	output logic                   irq,
	input  wire logic              nmi_pin,
	input  wire logic              ext_req_pin,
	input  wire logic [5:0]        timer_req,
	input  wire logic              serial_tx_done,
	input  wire logic              serial_rx_done,
	input  wire logic              adc_done,
	output logic                   bus_req,
	input  wire logic              bus_grant,
	output logic      [ADDR_W-1:0] sys_addr,
	output logic                   sys_read,
	output logic                   sys_write,
	output logic                   sys_word,
	output logic      [15:0]       sys_wdata,
	input  wire logic [15:0]       sys_rdata,
	input  wire logic              sys_done,
	output logic                   transfer_ack_strobe
);

	function automatic logic reg_hit(input logic [7:0] addr, input int unsigned ch,
		input logic [7:0] ofs);
		return addr == (DCC_CH_STRIDE * 8'(ch) + ofs);
	endfunction : reg_hit

	// External request only reaches B channels
	function automatic logic req_pick(input logic [15:0] mode, input logic [15:0] evts,
		input logic is_b);
		logic [3:0] sel;
		sel = mode[DCC_MD_REQ_LSB +: 4];
		return (sel == DCC_REQ_EXT && !is_b) ? 1'b0 : evts[sel];
	endfunction : req_pick

	function automatic logic [1:0] first_set(input logic [3:0] v);
		return v[0] ? 2'd0 : v[1] ? 2'd1 : v[2] ? 2'd2 : 2'd3;
	endfunction : first_set

	logic        [2:0]        nmi_s_q;
	logic        [2:0]        ext_s_q;
	logic                     nmi_lvl_q;
	logic                     ext_lvl_q;
	logic                     wait_q;
	logic        [31:0]       rdata_q;
	logic        [31:0]       rd_mux;
	logic        [1:0]        me_q;
	logic        [1:0]        armed_q;
	logic        [3:0]        te_q;
	logic        [3:0]        ie_q;
	logic        [3:0]        stat_q;
	logic        [3:0]        mask_q;
	logic                     irq_q;
	dcc_bus_st_t              st_q;
	logic        [1:0]        cur_q;
	logic                     bus_req_q;
	logic        [ADDR_W-1:0] addr_q;
	logic                     rd_q;
	logic                     wr_q;
	logic                     word_q;
	logic        [15:0]       wdata_q;
	logic                     ack_q;
	logic        [ADDR_W-1:0] mem_a [DCC_NUM_CH];
	logic        [ADDR_W-1:0] io_a [DCC_NUM_CH];
	logic        [15:0]       cnt_a [DCC_NUM_CH];
	logic        [15:0]       blk_a [DCC_NUM_CH];
	logic        [15:0]       mode_a [DCC_NUM_CH];
	logic        [3:0]        want_v;
	logic        [3:0]        end_v;
	logic        [3:0]        burst_v;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	wire nmi_rise = nmi_s_q[1] & nmi_s_q[2] & ~nmi_lvl_q;
	wire ext_rise = ext_s_q[1] & ext_s_q[2] & ~ext_lvl_q;

	always_ff @(posedge mclk) begin
		if (reset) begin
			nmi_s_q   <= 3'h0;
			ext_s_q   <= 3'h0;
			nmi_lvl_q <= 1'b0;
			ext_lvl_q <= 1'b0;
		end else if (en) begin
			nmi_s_q <= {nmi_s_q[1:0], nmi_pin};
			ext_s_q <= {ext_s_q[1:0], ext_req_pin};
			if (nmi_s_q[1] == nmi_s_q[2]) nmi_lvl_q <= nmi_s_q[1];
			if (ext_s_q[1] == ext_s_q[2]) ext_lvl_q <= ext_s_q[1];
		end
	end

	// ----------------------------------------------------------------
	// Register slave
	// ----------------------------------------------------------------
	// One wait cycle per access keeps readdata and waitrequest on flip-flops
	wire        rd_go    = en & avs_read & ~wait_q;
	wire        wr_go    = en & avs_write & ~wait_q;
	wire        wr_ctrl  = wr_go & (avs_address == DCC_OFS_CTRL_LOW);
	wire        rd_ctrl  = rd_go & (avs_address == DCC_OFS_CTRL_LOW);
	wire        wr_chen  = wr_go & (avs_address == DCC_OFS_CH_EN);
	wire        wr_stat  = wr_go & (avs_address == DCC_OFS_IRQ_STAT);
	wire        wr_mask  = wr_go & (avs_address == DCC_OFS_IRQ_MASK);
	wire [1:0]  rd_ch    = avs_address[6:5];
	wire [4:0]  reg_ofs  = avs_address[4:0];
	wire [7:0]  ctrl_rd  = (8'(me_q[1]) << DCC_CTRL_ME1_BIT) | (8'(me_q[0]) << DCC_CTRL_ME0_BIT);
	wire [1:0]  me_wbit  = {avs_writedata[DCC_CTRL_ME1_BIT], avs_writedata[DCC_CTRL_ME0_BIT]};
	wire [3:0]  te_wr    = avs_writedata[DCC_EN_TE_LSB +: 4];
	wire [1:0]  nmi_stop = {nmi_rise & me_q[1] & |(burst_v[3:2] & te_q[3:2]),
		nmi_rise & me_q[0] & |(burst_v[1:0] & te_q[1:0])};
	wire [1:0]  me_set   = {2{wr_ctrl}} & me_wbit & armed_q;
	wire [1:0]  me_clr   = ({2{wr_ctrl}} & ~me_wbit) | nmi_stop;

	always_comb begin
		rd_mux = 32'h0;
		if (avs_address == DCC_OFS_CTRL_LOW) begin
			rd_mux = 32'(ctrl_rd);
		end else if (avs_address == DCC_OFS_CH_EN) begin
			rd_mux = 32'({ie_q, te_q});
		end else if (avs_address == DCC_OFS_IRQ_STAT) begin
			rd_mux = 32'(stat_q);
		end else if (avs_address == DCC_OFS_IRQ_MASK) begin
			rd_mux = 32'(mask_q);
		end else if (!avs_address[7]) begin
			if (reg_ofs == DCC_OFS_MEM[4:0]) rd_mux = 32'(mem_a[rd_ch]);
			else if (reg_ofs == DCC_OFS_IO[4:0]) rd_mux = 32'(io_a[rd_ch]);
			else if (reg_ofs == DCC_OFS_CNT[4:0]) rd_mux = 32'(cnt_a[rd_ch]);
			else if (reg_ofs == DCC_OFS_MODE[4:0]) rd_mux = 32'(mode_a[rd_ch]);
			else if (reg_ofs == DCC_OFS_BLK[4:0]) rd_mux = 32'(blk_a[rd_ch]);
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0;
		end else if (en) begin
			wait_q <= ~((avs_read | avs_write) & wait_q);
			if (avs_read && wait_q) rdata_q <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// Enables and interrupt
	// ----------------------------------------------------------------
	// NMI clear wins over a software set in the same cycle
	always_ff @(posedge mclk) begin
		if (reset) begin
			me_q    <= DCC_ME_RST;
			armed_q <= 2'h0;
			te_q    <= DCC_TE_RST;
			ie_q    <= DCC_IE_RST;
			stat_q  <= 4'h0;
			mask_q  <= DCC_MASK_RST;
			irq_q   <= 1'b0;
		end else if (en) begin
			me_q    <= (me_q | me_set) & ~me_clr;
			armed_q <= rd_ctrl ? ~me_q : (wr_ctrl ? 2'h0 : armed_q);
			te_q    <= (wr_chen ? te_wr : te_q) & ~end_v;
			if (wr_chen) ie_q <= avs_writedata[DCC_EN_IE_LSB +: 4];
			if (wr_mask) mask_q <= avs_writedata[3:0];
			stat_q  <= (stat_q & ~({4{wr_stat}} & avs_writedata[3:0])) | (end_v & ie_q);
			irq_q   <= |(stat_q & mask_q);
		end
	end

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------
	wire [15:0] evts = {6'h0, ext_rise, adc_done, serial_rx_done, serial_tx_done, timer_req};
	wire        fin  = (st_q == DCC_ST_WRITE || st_q == DCC_ST_SINGLE) && sys_done;
	wire [3:0]  done_v = fin ? (4'h1 << cur_q) : 4'h0;

	for (genvar c = 0; c < DCC_NUM_CH; c++) begin : g_ch
		wire go = me_q[c / 2] & te_q[c];
		assign burst_v[c] = dcc_burst(mode_a[c]);
		dcc_chan #(
			.ADDR_W (ADDR_W)
		) u_chan (
			.mclk      (mclk),
			.reset     (reset),
			.en        (en),
			.wr_mem    (wr_go & reg_hit(avs_address, c, DCC_OFS_MEM)),
			.wr_io     (wr_go & reg_hit(avs_address, c, DCC_OFS_IO)),
			.wr_cnt    (wr_go & reg_hit(avs_address, c, DCC_OFS_CNT)),
			.wr_mode   (wr_go & reg_hit(avs_address, c, DCC_OFS_MODE)),
			.wr_blk    (wr_go & reg_hit(avs_address, c, DCC_OFS_BLK)),
			.wdata     (avs_writedata),
			.go        (go),
			.req_evt   (req_pick(mode_a[c], evts, 1'(c % 2))),
			.unit_done (en & done_v[c]),
			.mem_addr  (mem_a[c]),
			.io_addr   (io_a[c]),
			.cnt_now   (cnt_a[c]),
			.blk_now   (blk_a[c]),
			.mode      (mode_a[c]),
			.want      (want_v[c]),
			.end_evt   (end_v[c])
		);
	end

	// ----------------------------------------------------------------
	// Bus sequencer
	// ----------------------------------------------------------------
	wire [1:0]  pick     = first_set(want_v);
	wire [15:0] pick_md  = mode_a[pick];
	wire        pick_sa  = pick_md[DCC_MD_SINGLE_BIT] & pick[0];
	wire        pick_dir = pick_md[DCC_MD_DIR_BIT];
	wire        cur_dir  = mode_a[cur_q][DCC_MD_DIR_BIT];
	wire        start    = en & (st_q == DCC_ST_IDLE) & (|want_v) & bus_grant & bus_req_q;

	// The unit in flight always completes; an NMI stop takes effect between units
	always_ff @(posedge mclk) begin
		if (reset) begin
			st_q      <= DCC_ST_IDLE;
			cur_q     <= 2'd0;
			bus_req_q <= 1'b0;
			addr_q    <= '0;
			rd_q      <= 1'b0;
			wr_q      <= 1'b0;
			word_q    <= 1'b0;
			wdata_q   <= 16'h0000;
			ack_q     <= 1'b0;
		end else if (en) begin
			case (st_q)
				DCC_ST_IDLE: begin
					bus_req_q <= |want_v;
					if (start) begin
						cur_q  <= pick;
						word_q <= pick_md[DCC_MD_WORD_BIT];
						addr_q <= (pick_sa || !pick_dir) ? mem_a[pick] : io_a[pick];
						if (pick_sa) begin
							st_q  <= DCC_ST_SINGLE;
							rd_q  <= ~pick_dir;
							wr_q  <= pick_dir;
							ack_q <= 1'b1;
						end else begin
							st_q <= DCC_ST_READ;
							rd_q <= 1'b1;
						end
					end
				end
				DCC_ST_READ: begin
					if (sys_done) begin
						st_q    <= DCC_ST_WRITE;
						rd_q    <= 1'b0;
						wr_q    <= 1'b1;
						wdata_q <= sys_rdata;
						addr_q  <= cur_dir ? mem_a[cur_q] : io_a[cur_q];
					end
				end
				default: begin
					if (sys_done) begin
						st_q  <= DCC_ST_IDLE;
						rd_q  <= 1'b0;
						wr_q  <= 1'b0;
						ack_q <= 1'b0;
					end
				end
			endcase
		end
	end

	assign avs_readdata        = rdata_q;
	assign avs_waitrequest     = wait_q;
	assign irq                 = irq_q;
	assign bus_req             = bus_req_q;
	assign sys_addr            = addr_q;
	assign sys_read            = rd_q;
	assign sys_write           = wr_q;
	assign sys_word            = word_q;
	assign sys_wdata           = wdata_q;
	assign transfer_ack_strobe = ack_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking dcc_cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	enable_gate_a: assert property (start |-> me_q[pick[1]] && te_q[pick])
		else $error("transfer started without both enables");
	nmi_stop_a: assert property (en && nmi_rise && me_q[1] && |(burst_v[3:2] & te_q[3:2])
		|=> !me_q[1]) else $error("burst not stopped by nmi");
	resume_set_a: assert property (en && wr_ctrl && me_wbit[1] && armed_q[1] && !nmi_stop[1]
		|=> me_q[1]) else $error("master enable not set again");
	block_keep_a: assert property (en && nmi_rise && me_q[1] && !(|(burst_v[3:2] & te_q[3:2]))
		&& !wr_ctrl |=> me_q[1]) else $error("nmi cleared master enable in block mode");
	master_set_a: assert property (en && !me_q[1] && !(wr_ctrl && armed_q[1])
		|=> !me_q[1]) else $error("master enable set without read of zero");
	dual_cycle_a: assert property (en && st_q == DCC_ST_READ && sys_done
		|=> st_q == DCC_ST_WRITE && sys_write && !sys_read) else $error("write cycle missing");
	single_ack_a: assert property (transfer_ack_strobe |-> st_q == DCC_ST_SINGLE && cur_q[0])
		else $error("ack strobe outside single cycle on b channel");
	end_clear_a: assert property (en && |end_v |=> (te_q & $past(end_v)) == 4'h0)
		else $error("transfer enable not cleared at end");
	end_irq_a: assert property (en && |(end_v & ie_q) && !wr_stat |=> |stat_q ##1 (irq || !en
		|| (stat_q & mask_q) == 4'h0)) else $error("end interrupt not raised");

	nmi_cov: cover property (en && |nmi_stop);
	single_cov: cover property (en && st_q == DCC_ST_SINGLE && sys_done);
	block_end_cov: cover property (en && |(end_v & ie_q) ##[1:4] irq);

endmodule : dcc_ctrl

/* File: design/dcc_pkg.sv */
// Package: register map, field layout, reset values and types of the DMA channel control
package dcc_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int unsigned DCC_NUM_CH = 4;
	localparam int unsigned DCC_ADDR_W = 24;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] DCC_CH_STRIDE    = 8'h20;
	localparam logic [7:0] DCC_OFS_MEM      = 8'h00;
	localparam logic [7:0] DCC_OFS_IO       = 8'h04;
	localparam logic [7:0] DCC_OFS_CNT      = 8'h08;
	localparam logic [7:0] DCC_OFS_MODE     = 8'h0c;
	localparam logic [7:0] DCC_OFS_BLK      = 8'h10;
	localparam logic [7:0] DCC_OFS_CTRL_LOW = 8'h80;
	localparam logic [7:0] DCC_OFS_CH_EN    = 8'h84;
	localparam logic [7:0] DCC_OFS_IRQ_STAT = 8'h88;
	localparam logic [7:0] DCC_OFS_IRQ_MASK = 8'h8c;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned DCC_CTRL_ME1_BIT  = 7;
	localparam int unsigned DCC_CTRL_ME0_BIT  = 6;
	localparam int unsigned DCC_EN_TE_LSB     = 0;
	localparam int unsigned DCC_EN_IE_LSB     = 4;
	localparam int unsigned DCC_MD_XMODE_LSB  = 0;
	localparam int unsigned DCC_MD_WORD_BIT   = 2;
	localparam int unsigned DCC_MD_DOWN_BIT   = 3;
	localparam int unsigned DCC_MD_SINGLE_BIT = 4;
	localparam int unsigned DCC_MD_DIR_BIT    = 5;
	localparam int unsigned DCC_MD_BURST_BIT  = 6;
	localparam int unsigned DCC_MD_REQ_LSB    = 8;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [1:0]  DCC_ME_RST   = 2'h0;
	localparam logic [3:0]  DCC_TE_RST   = 4'h0;
	localparam logic [3:0]  DCC_IE_RST   = 4'h0;
	localparam logic [3:0]  DCC_MASK_RST = 4'h0;
	localparam logic [15:0] DCC_MODE_RST = 16'h0000;

	// ----------------------------------------------------------------
	// Request source codes
	// ----------------------------------------------------------------
	localparam logic [3:0] DCC_REQ_TXI = 4'h6;
	localparam logic [3:0] DCC_REQ_RXI = 4'h7;
	localparam logic [3:0] DCC_REQ_ADC = 4'h8;
	localparam logic [3:0] DCC_REQ_EXT = 4'h9;

	typedef enum logic [1:0] {
		DCC_XM_SEQ    = 2'b00,
		DCC_XM_IDLE   = 2'b01,
		DCC_XM_REPEAT = 2'b10,
		DCC_XM_BLOCK  = 2'b11
	} dcc_xmode_t;

	typedef enum logic [1:0] {
		DCC_ST_IDLE   = 2'b00,
		DCC_ST_READ   = 2'b01,
		DCC_ST_WRITE  = 2'b10,
		DCC_ST_SINGLE = 2'b11
	} dcc_bus_st_t;

	function automatic dcc_xmode_t dcc_xmode(input logic [15:0] mode);
		return dcc_xmode_t'(mode[DCC_MD_XMODE_LSB +: 2]);
	endfunction : dcc_xmode

	// Burst never applies in block mode
	function automatic logic dcc_burst(input logic [15:0] mode);
		return mode[DCC_MD_BURST_BIT] && (dcc_xmode(mode) != DCC_XM_BLOCK);
	endfunction : dcc_burst

endpackage : dcc_pkg

/* File: testbench/dcc_sys_model.sv */
// Partner model: system bus memory and peripheral answering DMA bus cycles
module dcc_sys_model
	import dcc_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  reset,
	input  wire logic                  bus_req,
	input  wire logic [DCC_ADDR_W-1:0] sys_addr,
	input  wire logic                  sys_read,
	input  wire logic                  sys_write,
	output logic                       bus_grant,
	output logic      [15:0]           sys_rdata,
	output logic                       sys_done,
	output int                         writes
);
	timeunit 1ns;
	timeprecision 1ps;
	int          n_q;
	logic        slow_q;
	logic [15:0] junk_q;
	// Outside the answer the data lines wander, so stale data never matches
	assign sys_rdata = (sys_read && sys_done) ? (sys_addr[15:0] ^ 16'h5a5a) : junk_q;
	always_ff @(posedge mclk) begin
		junk_q <= reset ? 16'h0001 : junk_q + 16'h3c71;
		bus_grant <= !reset && bus_req;
		if (reset) begin
			sys_done <= 0;
			n_q <= 0;
			slow_q <= 0;
			writes <= 0;
		end else if (sys_done) begin
			sys_done <= 0;
			n_q <= 0;
			slow_q <= !slow_q;
			writes <= writes + int'(sys_write);
		end else if (sys_read || sys_write) begin
			// Alternates prompt and slow answers to the strobe
			if (n_q >= (slow_q ? 3 : 0)) sys_done <= 1;
			else n_q <= n_q + 1;
		end
	end
endmodule : dcc_sys_model

/* File: testbench/tb_dma_channel_transfer_control.sv */
// Testbench: registers, transfers, NMI suspension and interrupt of the DMA channel control
module tb_dma_channel_transfer_control;
	import dcc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, reset, avs_read, avs_write, avs_waitrequest, irq, nmi_pin;
	logic        bus_req, bus_grant, sys_read, sys_write, sys_word, sys_done, ack;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rv, a;
	logic [5:0]  timer_req;
	logic [23:0] sys_addr, src_q[$];
	logic [15:0] sys_wdata, sys_rdata, dat_q[$];
	int          err_count, checks, seed, writes, i, tgt;
	always #5 mclk = ~mclk;
	dcc_ctrl dut (.mclk, .reset, .en(1'b1), .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .irq, .nmi_pin, .ext_req_pin(1'b0), .timer_req,
		.serial_tx_done(1'b0), .serial_rx_done(1'b0), .adc_done(1'b0), .bus_req, .bus_grant,
		.sys_addr, .sys_read, .sys_write, .sys_word, .sys_wdata, .sys_rdata, .sys_done,
		.transfer_ack_strobe(ack));
	dcc_sys_model bfm (.mclk, .reset, .bus_req, .sys_addr, .sys_read, .sys_write, .bus_grant,
		.sys_rdata, .sys_done, .writes);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wrap_up();
		if (err_count == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : wrap_up
	task automatic av(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int k;
		@(posedge mclk);
		avs_address <= ad;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		for (k = 0; k < 50; k++) begin
			@(posedge mclk);
			if (avs_waitrequest === 1'b0) break;
		end
		if (k == 50) begin
			err_count++;
			wrap_up();
		end
		rv = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
	endtask : av
	task automatic waitfor(input int sel);
		for (int k = 0; k < 2000; k++) begin
			@(posedge mclk);
			if (sel == 0 ? writes >= tgt : sel == 1 ? bus_req === 1'b0 : irq === 1'b1) return;
		end
		err_count++;
		wrap_up();
	endtask : waitfor
	// Model: expected source addresses queued ahead, write data follows read data
	always @(posedge mclk) begin
		if (sys_done === 1'b1 && sys_read === 1'b1) begin
			chk(32'(sys_addr), 32'(src_q.pop_front()));
			chk(32'(sys_word), 32'h1);
			chk(32'(ack), 32'h0);
			dat_q.push_back(sys_addr[15:0] ^ 16'h5a5a);
		end else if (sys_done === 1'b1 && sys_write === 1'b1) begin
			chk(32'(sys_addr), 32'h100);
			chk(32'(sys_wdata), 32'(dat_q.pop_front()));
		end
	end
	initial begin
		{mclk, reset, avs_read, avs_write, avs_address, avs_writedata} = 43'h1_0000_0000_00 >> 1;
		{nmi_pin, timer_req, err_count, checks, seed} = {7'h0, 64'h0, 32'h6b49f670};
		reset = 1;
		repeat (2) @(posedge mclk);
		reset <= 0;
		av(0, 8'h80, 0); chk(rv, 0);
		av(1, 8'h80, 0);
		av(1, 8'h80, 32'h80);
		av(0, 8'h80, 0); chk(rv, 0);
		av(1, 8'h80, 32'h80);
		av(0, 8'h80, 0); chk(rv, 32'h80);
		a = $random(seed) & 32'h00fff0;
		src_q = {a[23:0], a[23:0] + 24'h2};
		av(1, 8'h60, a);
		av(1, 8'h64, 32'h100);
		av(1, 8'h68, 32'h2);
		av(1, 8'h6c, 32'h4);
		av(1, 8'h8c, 32'h8);
		av(1, 8'h84, 32'h88);
		for (i = 1; i <= 2; i++) begin
			@(posedge mclk) timer_req <= 6'h1;
			@(posedge mclk) timer_req <= 6'h0;
			tgt = i;
			waitfor(0);
		end
		waitfor(2);
		av(0, 8'h60, 0); chk(rv, a + 32'h4);
		av(0, 8'h84, 0); chk(rv, 32'h80);
		av(1, 8'h88, 32'h8);
		repeat (2) @(posedge mclk);
		chk(32'(irq), 32'h0);
		a = $random(seed) & 32'h00fff0;
		for (i = 0; i < 6; i++) src_q.push_back(a[23:0] + 24'(2 * i));
		av(1, 8'h60, a);
		av(1, 8'h68, 32'h6);
		av(1, 8'h6c, 32'h44);
		av(1, 8'h84, 32'h88);
		tgt = 4;
		waitfor(0);
		nmi_pin <= 1;
		repeat (6) @(posedge mclk);
		nmi_pin <= 0;
		waitfor(1);
		av(0, 8'h80, 0); chk(rv, 0);
		chk(32'(writes < 8), 32'h1);
		av(1, 8'h80, 32'h80);
		tgt = 8;
		waitfor(0);
		waitfor(2);
		av(0, 8'h60, 0); chk(rv, a + 32'hc);
		chk(32'(writes), 32'd8);
		// Block mode: two blocks of two units, an NMI edge lands inside the first
		a = $random(seed) & 32'h00fff0;
		for (i = 0; i < 4; i++) src_q.push_back(a[23:0] + 24'(2 * i));
		av(1, 8'h88, 32'h8);
		av(1, 8'h60, a);
		av(1, 8'h68, 32'h2);
		av(1, 8'h70, 32'h2);
		av(1, 8'h6c, 32'h47);
		av(1, 8'h84, 32'h88);
		for (i = 1; i <= 2; i++) begin
			@(posedge mclk) timer_req <= 6'h1;
			@(posedge mclk) timer_req <= 6'h0;
			nmi_pin <= !nmi_pin;
			tgt = 8 + 2 * i;
			waitfor(0);
		end
		waitfor(2);
		av(0, 8'h80, 0);
		chk(rv, 32'h80);
		av(0, 8'h84, 0);
		chk(rv, 32'h80);
		av(0, 8'h70, 0);
		chk(rv, 32'h0);
		av(0, 8'h60, 0);
		chk(rv, a + 32'h8);
		chk(32'(writes), 32'd12);
		wrap_up();
	end
endmodule : tb_dma_channel_transfer_control
